// ==== wake_interrupt_dispatch.sv ====
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Overview of operation
// [RULE1] timer-use overflow: idle wake, run interrupt
// [RULE2] counter-use overflow: sleep/idle wake, run interrupt
// [RULE3] primary enable off: overflow does nothing
// [RULE4] pwm period match: idle wake, no sleep
// [RULE5] pwm period enable off: no effect
// [RULE6] pwm duty match behaves like period
// [RULE7] aux timer-use: idle wake, run interrupt
// [RULE8] aux counter-use: sleep/idle wake, interrupt
// [RULE9] pin enables both off: nothing
// [RULE10] pin irq only: interrupt, no wake
// [RULE11] pin wake only: wake, next instruction
// [RULE12] pin both: wake and interrupt
// [RULE13] global off resumes, global on vectors
// [RULE14] sleep stops oscillator and timers
// [RULE15] watchdog at sleep blocks all wakes
// [RULE16] wake uses global state saved at sleep
module wake_interrupt_dispatch
  import wake_dispatch_pkg::*;
#(
  parameter int NUM_EXT = 2
) (
  input logic ref_clk_in,
  input logic rst_b_in,
  input logic psel_in,
  input logic penable_in,
  input logic pwrite_in,
  input logic [7:0] paddr_in,
  input logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input power_mode_t power_mode_in,
  input logic sleep_instruction_in,
  input logic global_irq_on_in,
  input logic global_irq_off_in,
  input logic watchdog_en_in,
  input logic primary_timer_ovf_in,
  input logic [NUM_PWM-1:0] pwm_period_match_in,
  input logic [NUM_PWM-1:0] pwm_duty_match_in,
  input logic [NUM_AUX-1:0] aux_timer_evt_in,
  input logic [NUM_EXT-1:0] ext_pin_in,
  output logic wake_out,
  output logic vector_out,
  output logic next_instr_out,
  output logic clock_stop_out,
  output logic irq_out
);

  localparam int NSRC = SRC_EXT + NUM_EXT;

  logic primary_timer_irq_en;
  logic primary_timer_cnt;
  logic [NUM_PWM-1:0] pwm_period_irq_en;
  logic [NUM_PWM-1:0] pwm_duty_irq_en;
  logic [NUM_AUX-1:0] aux_timer_irq_en;
  logic [NUM_AUX-1:0] aux_timer_cnt;
  logic [NUM_EXT-1:0] ext_pin_wake_en;
  logic [NUM_EXT-1:0] ext_pin_irq_en;
  logic [NSRC-1:0] status;
  logic [NSRC-1:0] irq_en;
  logic [NSRC-1:0] wake_src;
  logic gie;
  logic saved_gie;
  logic wd_lock;
  logic [NUM_EXT-1:0] ext_ev;
  logic [NSRC-1:0] ev;
  logic [NSRC-1:0] ie_vec;
  logic [NSRC-1:0] sleep_wk;
  logic [NSRC-1:0] idle_wk;
  logic [NSRC-1:0] wk_sel;
  logic [NSRC-1:0] irq_sel;
  logic [NSRC-1:0] hit_wake;
  logic [NSRC-1:0] hit_irq;
  logic [NSRC-1:0] clr_mask;
  logic any_wake;
  logic any_irq;
  logic vec_wake;
  logic acc;
  logic wr_acc;
  logic [31:0] rdata;
  logic mapped;

  // ************************************************************
  // external pin change events
  // ************************************************************
  ext_pin_edge #(
    .WIDTH(NUM_EXT)
  ) u_ext_edge (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(ext_pin_in),
    .change_out(ext_ev)
  );

  // ************************************************************
  // per source enables by mode
  // ************************************************************
  assign ev = {ext_ev, aux_timer_evt_in, pwm_duty_match_in,
               pwm_period_match_in, primary_timer_ovf_in};
  assign ie_vec = {ext_pin_irq_en, aux_timer_irq_en, pwm_duty_irq_en,
                   pwm_period_irq_en, primary_timer_irq_en}; // RULE9 RULE10
  // sleep wake only from counter use and pin wake enables
  assign sleep_wk = {ext_pin_wake_en, aux_timer_irq_en & aux_timer_cnt,
                     {NUM_PWM{1'b0}}, {NUM_PWM{1'b0}},
                     primary_timer_irq_en & primary_timer_cnt}; // RULE2 RULE4 RULE6 RULE8 RULE11
  // idle wake from every enabled timer, pwm, and pin wake enables
  assign idle_wk = {ext_pin_wake_en, aux_timer_irq_en, pwm_duty_irq_en,
                    pwm_period_irq_en, primary_timer_irq_en}; // RULE1 RULE5 RULE7 RULE12

  always_comb begin
    wk_sel = '0;
    irq_sel = '0;
    case (power_mode_in)
      MODE_SLEEP: begin
        wk_sel = sleep_wk & {NSRC{~wd_lock}}; // RULE15
      end
      MODE_IDLE: begin
        wk_sel = idle_wk & {NSRC{~wd_lock}}; // RULE15
      end
      MODE_GREEN, MODE_NORMAL: begin
        irq_sel = ie_vec; // RULE3
      end
      default: begin
        wk_sel = '0;
        irq_sel = '0;
      end
    endcase
  end

  assign hit_wake = ev & wk_sel;
  assign hit_irq = ev & irq_sel;
  assign any_wake = |hit_wake;
  assign any_irq = |hit_irq;
  // wake with irq enable vectors only if global was on at sleep
  assign vec_wake = saved_gie & (|(hit_wake & ie_vec)); // RULE16 RULE11 RULE12

  // ************************************************************
  // program flow outcome to the core
  // ************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wake_out <= 1'b0;
      vector_out <= 1'b0;
      next_instr_out <= 1'b0;
    end else begin
      wake_out <= any_wake;
      if (any_wake) begin
        vector_out <= vec_wake; // RULE13
        next_instr_out <= ~vec_wake; // RULE13
      end else begin
        vector_out <= any_irq & gie; // RULE13
        next_instr_out <= any_irq & ~gie; // RULE13
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      clock_stop_out <= 1'b0;
    end else begin
      clock_stop_out <= (power_mode_in == MODE_SLEEP); // RULE14
    end
  end

  // ************************************************************
  // global interrupt state and sleep capture
  // ************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      gie <= 1'b0;
    end else if (global_irq_on_in) begin
      gie <= 1'b1;
    end else if (global_irq_off_in) begin
      gie <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      saved_gie <= 1'b0;
    end else if (sleep_instruction_in) begin
      saved_gie <= gie; // RULE16
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wd_lock <= 1'b0;
    end else if (sleep_instruction_in) begin
      wd_lock <= watchdog_en_in; // RULE15
    end else if (power_mode_in == MODE_GREEN || power_mode_in == MODE_NORMAL) begin
      wd_lock <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wake_src <= '0;
    end else if (any_wake) begin
      wake_src <= hit_wake;
    end
  end

  // ************************************************************
  // sticky status and interrupt line
  // ************************************************************
  assign clr_mask = (wr_acc && paddr_in == OFS_CLEAR) ? pwdata_in[NSRC-1:0] : '0;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_mask) | hit_wake | hit_irq;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & irq_en);
    end
  end

  // ************************************************************
  // apb slave
  // ************************************************************
  assign acc = psel_in & penable_in & pready_out;
  assign wr_acc = acc & pwrite_in;

  always_comb begin
    rdata = WORD_ZERO;
    mapped = 1'b1;
    case (paddr_in)
      OFS_CFG: begin
        rdata[CFG_PT_IE] = primary_timer_irq_en;
        rdata[CFG_PT_CNT] = primary_timer_cnt;
        rdata[CFG_PWM_P +: NUM_PWM] = pwm_period_irq_en;
        rdata[CFG_PWM_D +: NUM_PWM] = pwm_duty_irq_en;
        rdata[CFG_AUX_IE +: NUM_AUX] = aux_timer_irq_en;
        rdata[CFG_AUX_CNT +: NUM_AUX] = aux_timer_cnt;
      end
      OFS_EXT: begin
        rdata[EXT_WK_POS +: NUM_EXT] = ext_pin_wake_en;
        rdata[EXT_IE_POS +: NUM_EXT] = ext_pin_irq_en;
      end
      OFS_STATUS: begin
        rdata[NSRC-1:0] = status;
      end
      OFS_CLEAR: begin
        rdata = WORD_ZERO;
      end
      OFS_IRQ_EN: begin
        rdata[NSRC-1:0] = irq_en;
      end
      OFS_STATE: begin
        rdata[STATE_MODE +: 2] = power_mode_in;
        rdata[STATE_GIE] = gie;
        rdata[STATE_SAVED] = saved_gie;
        rdata[STATE_WDL] = wd_lock;
        rdata[STATE_STOP] = clock_stop_out;
      end
      OFS_WAKE_SRC: begin
        rdata[NSRC-1:0] = wake_src;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= WORD_ZERO;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
      if (psel_in && penable_in && !pready_out) begin
        prdata_out <= pwrite_in ? WORD_ZERO : rdata;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      primary_timer_irq_en <= 1'b0;
      primary_timer_cnt <= 1'b0;
      pwm_period_irq_en <= '0;
      pwm_duty_irq_en <= '0;
      aux_timer_irq_en <= '0;
      aux_timer_cnt <= '0;
    end else if (wr_acc && paddr_in == OFS_CFG) begin
      primary_timer_irq_en <= pwdata_in[CFG_PT_IE];
      primary_timer_cnt <= pwdata_in[CFG_PT_CNT];
      pwm_period_irq_en <= pwdata_in[CFG_PWM_P +: NUM_PWM];
      pwm_duty_irq_en <= pwdata_in[CFG_PWM_D +: NUM_PWM];
      aux_timer_irq_en <= pwdata_in[CFG_AUX_IE +: NUM_AUX];
      aux_timer_cnt <= pwdata_in[CFG_AUX_CNT +: NUM_AUX];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ext_pin_wake_en <= '0;
      ext_pin_irq_en <= '0;
    end else if (wr_acc && paddr_in == OFS_EXT) begin
      ext_pin_wake_en <= pwdata_in[EXT_WK_POS +: NUM_EXT];
      ext_pin_irq_en <= pwdata_in[EXT_IE_POS +: NUM_EXT];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      irq_en <= '0;
    end else if (wr_acc && paddr_in == OFS_IRQ_EN) begin
      irq_en <= pwdata_in[NSRC-1:0];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  localparam logic [NSRC-1:0] PT_ONLY = NSRC'(1) << SRC_PT;
  localparam logic [NSRC-1:0] PWMP_ONLY = NSRC'(1) << SRC_PWM_P;
  localparam logic [NSRC-1:0] PWMD_ONLY = NSRC'(1) << SRC_PWM_D;
  localparam logic [NSRC-1:0] AUX_ONLY = NSRC'(1) << SRC_AUX;
  localparam logic [NSRC-1:0] EXT_ONLY = NSRC'(1) << SRC_EXT;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_idle_timer_wake;
    (power_mode_in == MODE_IDLE && ev == PT_ONLY && primary_timer_irq_en && !wd_lock)
      |=> wake_out;
  endproperty
  a_idle_timer_wake: assert property (p_idle_timer_wake) else $error("idle timer no wake"); // RULE1

  property p_sleep_counter_wake;
    (power_mode_in == MODE_SLEEP && ev == PT_ONLY && primary_timer_irq_en
     && primary_timer_cnt && !wd_lock) |=> wake_out && vector_out == $past(saved_gie);
  endproperty
  a_sleep_counter_wake: assert property (p_sleep_counter_wake) else $error("counter wake bad"); // RULE2

  property p_pt_off_silent;
    (ev == PT_ONLY && !primary_timer_irq_en) |=> !wake_out && !vector_out && !next_instr_out;
  endproperty
  a_pt_off_silent: assert property (p_pt_off_silent) else $error("disabled timer acted"); // RULE3

  property p_pwm_no_sleep_wake;
    (power_mode_in == MODE_SLEEP && (ev == PWMP_ONLY || ev == PWMD_ONLY)) |=> !wake_out;
  endproperty
  a_pwm_no_sleep_wake: assert property (p_pwm_no_sleep_wake) else $error("pwm woke sleep"); // RULE4

  property p_duty_irq_status;
    (power_mode_in == MODE_GREEN && ev == PWMD_ONLY && pwm_duty_irq_en[0])
      |=> status[SRC_PWM_D] && (vector_out != next_instr_out);
  endproperty
  a_duty_irq_status: assert property (p_duty_irq_status) else $error("duty irq lost"); // RULE6

  property p_aux_count_sleep;
    (power_mode_in == MODE_SLEEP && ev == AUX_ONLY && aux_timer_irq_en[0]
     && aux_timer_cnt[0] && !wd_lock) |=> wake_out;
  endproperty
  a_aux_count_sleep: assert property (p_aux_count_sleep) else $error("aux count no wake"); // RULE8

  property p_pin_no_wake;
    (power_mode_in != MODE_GREEN && power_mode_in != MODE_NORMAL && ev == EXT_ONLY
     && !ext_pin_wake_en[0]) |=> !wake_out;
  endproperty
  a_pin_no_wake: assert property (p_pin_no_wake) else $error("pin woke disabled"); // RULE10

  property p_run_no_vector;
    (power_mode_in == MODE_NORMAL && any_irq && !gie) |=> next_instr_out && !vector_out;
  endproperty
  a_run_no_vector: assert property (p_run_no_vector) else $error("vector with global off"); // RULE13

  property p_sleep_stop;
    (power_mode_in == MODE_SLEEP) |=> clock_stop_out;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("clock not stopped"); // RULE14

  property p_wd_block;
    (wd_lock && power_mode_in == MODE_SLEEP) |=> !wake_out;
  endproperty
  a_wd_block: assert property (p_wd_block) else $error("wake under watchdog"); // RULE15

  property p_save_gie;
    sleep_instruction_in |=> saved_gie == $past(gie);
  endproperty
  a_save_gie: assert property (p_save_gie) else $error("global state not saved"); // RULE16

  c_sleep_wake: cover property (power_mode_in == MODE_SLEEP ##1 wake_out);
  c_run_vector: cover property (power_mode_in == MODE_NORMAL ##1 vector_out);
  c_idle_next: cover property (power_mode_in == MODE_IDLE ##1 next_instr_out);

endmodule : wake_interrupt_dispatch

// ==== wake_dispatch_pkg.sv ====
package wake_dispatch_pkg;

  // ************************************************************
  // source counts and source bit positions
  // ************************************************************
  localparam int NUM_PWM = 3;
  localparam int NUM_AUX = 3;
  localparam int SRC_PT = 0;
  localparam int SRC_PWM_P = 1;
  localparam int SRC_PWM_D = SRC_PWM_P + NUM_PWM;
  localparam int SRC_AUX = SRC_PWM_D + NUM_PWM;
  localparam int SRC_EXT = SRC_AUX + NUM_AUX;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_EXT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CLEAR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_WAKE_SRC = 8'h18;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CFG_PT_IE = 0;
  localparam int CFG_PT_CNT = 1;
  localparam int CFG_PWM_P = 2;
  localparam int CFG_PWM_D = CFG_PWM_P + NUM_PWM;
  localparam int CFG_AUX_IE = CFG_PWM_D + NUM_PWM;
  localparam int CFG_AUX_CNT = CFG_AUX_IE + NUM_AUX;
  localparam int EXT_WK_POS = 0;
  localparam int EXT_IE_POS = 16;
  localparam int STATE_MODE = 0;
  localparam int STATE_GIE = 2;
  localparam int STATE_SAVED = 3;
  localparam int STATE_WDL = 4;
  localparam int STATE_STOP = 5;

  // ************************************************************
  // reset values and modes
  // ************************************************************
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_IDLE,
    MODE_GREEN,
    MODE_NORMAL
  } power_mode_t;

endpackage : wake_dispatch_pkg

// ==== ext_pin_edge.sv ====
`timescale 1ns/100ps
module ext_pin_edge #(
  parameter int WIDTH = 2
) (
  input logic ref_clk_in,
  input logic rst_b_in,
  input logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] change_out
);

  // ************************************************************
  // per pin synchroniser and change detect
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic sync1;
      logic sync2;
      logic last;
      always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
          sync1 <= 1'b0;
          sync2 <= 1'b0;
          last <= 1'b0;
          change_out[i] <= 1'b0;
        end else begin
          sync1 <= pin_in[i];
          sync2 <= sync1;
          last <= sync2;
          change_out[i] <= sync2 ^ last;
        end
      end
    end
  endgenerate

endmodule : ext_pin_edge

// ==== wake_source_model.sv ====
`timescale 1ns/100ps
module wake_source_model
  import wake_dispatch_pkg::*;
#(
  parameter int NUM_EXT = 2
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic fire_in,
  input wire logic [3:0] src_in,
  output logic primary_timer_ovf_out,
  output logic [NUM_PWM-1:0] pwm_period_match_out,
  output logic [NUM_PWM-1:0] pwm_duty_match_out,
  output logic [NUM_AUX-1:0] aux_timer_evt_out,
  output logic [NUM_EXT-1:0] ext_pin_out
);
  // ************************************************************
  // one pulse per event, pins toggle level
  // ************************************************************
  logic [31:0] hit;
  assign hit = fire_in ? (32'h0000_0001 << src_in) : WORD_ZERO;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      primary_timer_ovf_out <= 1'b0;
      pwm_period_match_out <= {NUM_PWM{1'b0}};
      pwm_duty_match_out <= {NUM_PWM{1'b0}};
      aux_timer_evt_out <= {NUM_AUX{1'b0}};
      ext_pin_out <= {NUM_EXT{1'b0}};
    end else begin
      primary_timer_ovf_out <= hit[SRC_PT];
      pwm_period_match_out <= hit[SRC_PWM_P +: NUM_PWM];
      pwm_duty_match_out <= hit[SRC_PWM_D +: NUM_PWM];
      aux_timer_evt_out <= hit[SRC_AUX +: NUM_AUX];
      ext_pin_out <= ext_pin_out ^ hit[SRC_EXT +: NUM_EXT];
    end
  end
endmodule : wake_source_model

// ==== wake_interrupt_dispatch_tb.sv ====
`timescale 1ns/100ps
module wake_interrupt_dispatch_tb
  import wake_dispatch_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, e;
  power_mode_t power_mode = MODE_NORMAL;
  logic sleep_i = 1'b0, gon = 1'b0, goff = 1'b0, wd_en = 1'b0;
  logic fire = 1'b0;
  logic [3:0] src = 4'h0;
  logic pt_ovf, wake, vec, nxt, cstop, irq;
  logic [2:0] pwm_p, pwm_d, aux;
  logic [1:0] pins;
  logic [2:0] seen;
  logic [3:0] x;
  logic [31:0] cfg, ext;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  wake_source_model #(.NUM_EXT(2)) i_src (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .fire_in(fire), .src_in(src), .primary_timer_ovf_out(pt_ovf),
    .pwm_period_match_out(pwm_p), .pwm_duty_match_out(pwm_d),
    .aux_timer_evt_out(aux), .ext_pin_out(pins));

  wake_interrupt_dispatch #(.NUM_EXT(2)) i_dut (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .power_mode_in(power_mode), .sleep_instruction_in(sleep_i),
    .global_irq_on_in(gon), .global_irq_off_in(goff), .watchdog_en_in(wd_en),
    .primary_timer_ovf_in(pt_ovf), .pwm_period_match_in(pwm_p),
    .pwm_duty_match_in(pwm_d), .aux_timer_evt_in(aux), .ext_pin_in(pins),
    .wake_out(wake), .vector_out(vec), .next_instr_out(nxt), .clock_stop_out(cstop),
    .irq_out(irq));

  // ************************************************************
  // tasks
  // ************************************************************
  task conclude;
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task pulse_gie(input logic g);
    @(posedge ref_clk_in); gon <= g; goff <= !g;
    @(posedge ref_clk_in); gon <= 1'b0; goff <= 1'b0;
  endtask : pulse_gie

  task enter(input int m, input logic wd);
    @(posedge ref_clk_in); power_mode <= power_mode_t'(m); wd_en <= wd; sleep_i <= (m < 2);
    @(posedge ref_clk_in); sleep_i <= 1'b0;
  endtask : enter

  task fire_watch(input int s);
    @(posedge ref_clk_in); fire <= 1'b1; src <= s[3:0];
    @(posedge ref_clk_in); fire <= 1'b0;
    seen = 3'b000;
    repeat (8) begin @(negedge ref_clk_in); seen = seen | {wake, vec, nxt}; end
  endtask : fire_watch

  // returns {hit, wake, vector, next}
  function automatic logic [3:0] expect_of(int m, logic g, logic [31:0] c, logic [31:0] xe,
                                           int s);
    logic ie, cn, ok, vv;
    ie = (s == 0) ? c[0] : (s < 10) ? c[s+1] : xe[s+6];
    cn = (s == 0) ? c[1] : (s < 7) ? 1'b0 : (s < 10) ? c[s+4] : xe[s-10];
    ok = (m == 0) ? ((s >= 10) ? cn : ie & cn) : (m == 1) ? ((s >= 10) ? cn : ie) : ie;
    vv = ok & g & ie;
    return {ok, ok & (m < 2), vv, ok & !vv};
  endfunction : expect_of

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk("reset value", 32'h0000_0000, q);
    end
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, q);
    apb(1'b1, OFS_IRQ_EN, 32'hFFFF_FFFF);
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 2; g++) begin
        for (int v = 0; v < 4; v++) begin
          cfg = (v[0] ? 32'h0000_07FD : 32'h0) | (v[1] ? 32'h0000_3802 : 32'h0);
          ext = (v[0] ? 32'h0003_0000 : 32'h0) | (v[1] ? 32'h0000_0003 : 32'h0);
          apb(1'b1, OFS_CFG, cfg);
          apb(1'b1, OFS_EXT, ext);
          pulse_gie(g[0]);
          enter(m, 1'b0);
          if (m < 2) pulse_gie(!g[0]);
          @(negedge ref_clk_in);
          chk("clock_stop", {31'h0, m == 0}, {31'h0, cstop});
          for (int s = 0; s < 12; s++) begin
            x = expect_of(m, g[0], cfg, ext, s);
            fire_watch(s);
            chk("wake", {31'h0, x[2]}, {31'h0, seen[2]});
            chk("vector", {31'h0, x[1]}, {31'h0, seen[1]});
            chk("next", {31'h0, x[0]}, {31'h0, seen[0]});
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            chk("status", x[3] ? (32'h0000_0001 << s) : 32'h0, q);
            chk("irq", {31'h0, x[3]}, {31'h0, irq});
            apb(1'b1, OFS_CLEAR, 32'hFFFF_FFFF);
          end
        end
      end
    end
    apb(1'b1, OFS_EXT, 32'h0000_0003);
    for (int m = 0; m < 2; m++) begin
      enter(m, 1'b1);
      fire_watch(10 + m);
      chk("wd wake", 32'h0000_0000, {29'h0, seen});
      apb(1'b0, OFS_STATE, 32'h0000_0000);
      chk("state", 32'h0000_001C | (m == 0 ? 32'h0000_0020 : 32'h0000_0001), q);
    end
    enter(3, 1'b0);
    apb(1'b1, OFS_CLEAR, 32'hFFFF_FFFF);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_0000);
    apb(1'b1, OFS_CFG, 32'h0000_0001);
    fire_watch(0);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
    repeat (2) @(negedge ref_clk_in);
    chk("irq enabled", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, OFS_CLEAR, 32'h0000_0001);
    repeat (2) @(negedge ref_clk_in);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    conclude();
  end
endmodule : wake_interrupt_dispatch_tb
